// *** verilog/ofp_host.sv ***
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ofp_defines.svh"
module ofp_host
  import ofp_pkg::*;
#(
  parameter int PULL_GAP_CYC = `OFP_PULL_GAP_CYC
) (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST_B,
  // Avalon-MM slave
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Register link
  ofp_link_if.host         LINK
);
  ofp_state_t  state;
  logic [31:0] ratio;
  logic [19:0] div_cfg;
  logic [26:0] pull_cfg;
  logic [3:0]  range_cfg;
  logic [15:0] drvsel_rd;
  logic        prog_pend;
  logic        pull_pend;
  logic        range_pend;
  logic [12:0] gap_cnt;
  logic        av_go;
  logic        ctrl_wr;
  logic        start;

  assign av_go   = (AVS_READ | AVS_WRITE) & ~AVS_WAITREQUEST;
  assign ctrl_wr = av_go & AVS_WRITE & AVS_ADDRESS == `OFP_AV_CTRL;
  assign start   = state == OFP_IDLE;

  // One wait cycle, the access lands on the edge with waitrequest low
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      AVS_READDATA <= 32'h00000000;
    end else if (AVS_READ & AVS_WAITREQUEST) begin
      unique case (AVS_ADDRESS)
        `OFP_AV_STATUS: AVS_READDATA <= {drvsel_rd, 13'h0000,
                                         range_pend, pull_pend,
                                         ~start | prog_pend};
        `OFP_AV_RATIO:  AVS_READDATA <= ratio;
        `OFP_AV_DIV:    AVS_READDATA <= {12'h000, div_cfg};
        `OFP_AV_PULL:   AVS_READDATA <= {5'h00, pull_cfg};
        `OFP_AV_RANGE:  AVS_READDATA <= {28'h0000000, range_cfg};
        default:        AVS_READDATA <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ratio     <= 32'h00000000;
      div_cfg   <= 20'h00000;
      pull_cfg  <= 27'h0000000;
      range_cfg <= 4'h0;
    end else if (av_go & AVS_WRITE) begin
      unique case (AVS_ADDRESS)
        `OFP_AV_RATIO: ratio     <= AVS_WRITEDATA;
        `OFP_AV_DIV:   div_cfg   <= AVS_WRITEDATA[19:0];
        `OFP_AV_PULL:  pull_cfg  <= AVS_WRITEDATA[26:0];
        `OFP_AV_RANGE: range_cfg <= AVS_WRITEDATA[3:0];
        default: begin
        end
      endcase
    end
  end

  // Pending commands; a new order wins over the clear
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      prog_pend  <= 1'b0;
      pull_pend  <= 1'b0;
      range_pend <= 1'b0;
    end else begin
      prog_pend  <= (prog_pend & ~(start & prog_pend)) |
                    (ctrl_wr & AVS_WRITEDATA[`OFP_CTRL_PROG]);
      range_pend <= (range_pend & ~(start & ~prog_pend & range_pend)) |
                    (ctrl_wr & AVS_WRITEDATA[`OFP_CTRL_RANGE]);
      pull_pend  <= (pull_pend & ~(start & ~prog_pend & ~range_pend &
                                   gap_cnt == 13'h0000)) |
                    (ctrl_wr & AVS_WRITEDATA[`OFP_CTRL_PULL]);
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      gap_cnt <= 13'h0000;
    end else if (state == OFP_WRH && LINK.ack) begin
      gap_cnt <= 13'(PULL_GAP_CYC - 1);
    end else if (gap_cnt != 13'h0000) begin
      gap_cnt <= gap_cnt - 13'h0001;
    end
  end

  // upper select bits kept from readback
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      drvsel_rd <= 16'h0000;
    end else if (state == OFP_RD6 && LINK.ack) begin
      drvsel_rd <= LINK.rdata;
    end
  end

  // sequencer, one link access per state other than OFP_IDLE
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= OFP_IDLE;
    end else begin
      unique case (state)
        OFP_IDLE: begin
          if (prog_pend) begin
            state <= OFP_RD6;
          end else if (range_pend) begin
            state <= OFP_WRR;
          end else if (pull_pend && gap_cnt == 13'h0000) begin
            state <= OFP_WRL;
          end
        end
        OFP_RD6: if (LINK.ack) state <= OFP_WR3;
        OFP_WR3: if (LINK.ack) state <= OFP_WR4;
        OFP_WR4: if (LINK.ack) state <= OFP_WR6;
        OFP_WR6: if (LINK.ack) state <= OFP_WR5;
        OFP_WRL: if (LINK.ack) state <= OFP_WRH;
        OFP_WR5, OFP_WRH, OFP_WRR: if (LINK.ack) state <= OFP_IDLE;
      endcase
    end
  end

  // Link request raised a cycle after each state other than OFP_IDLE is entered
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      LINK.req   <= 1'b0;
      LINK.wr    <= 1'b0;
      LINK.addr  <= 3'h0;
      LINK.wdata <= 16'h0000;
    end else if (LINK.ack | start) begin
      LINK.req <= 1'b0;
    end else if (!LINK.req) begin
      LINK.req <= 1'b1;
      LINK.wr  <= state != OFP_RD6;
      unique case (state)
        OFP_RD6: begin
          LINK.addr  <= `OFP_REG_DRVSEL;
          LINK.wdata <= 16'h0000;
        end
        OFP_WR3: begin
          LINK.addr  <= `OFP_REG_RATIO_HI;
          LINK.wdata <= ratio[31:16];
        end
        OFP_WR4: begin
          LINK.addr  <= `OFP_REG_RATIO_LO;
          LINK.wdata <= ratio[15:0];
        end
        OFP_WR6: begin
          LINK.addr  <= `OFP_REG_DRVSEL;
          LINK.wdata <= {drvsel_rd[15:4], div_cfg[19], div_cfg[15:13]};
        end
        OFP_WR5: begin
          LINK.addr  <= `OFP_REG_DIVIDER;
          LINK.wdata <= {div_cfg[12:0], div_cfg[18:16]};
        end
        OFP_WRL: begin
          LINK.addr  <= `OFP_REG_PULL_LO;
          LINK.wdata <= pull_cfg[15:0];
        end
        // enable bit sent with the high word
        OFP_WRH: begin
          LINK.addr  <= `OFP_REG_PULL_HI;
          LINK.wdata <= {5'h00, pull_cfg[26], pull_cfg[25:16]};
        end
        default: begin
          LINK.addr  <= `OFP_REG_RANGE;
          LINK.wdata <= {12'h000, range_cfg};
        end
      endcase
    end
  end
endmodule : ofp_host
`default_nettype wire

// *** common/ofp_defines.svh ***
`ifndef OFP_DEFINES_SVH
`define OFP_DEFINES_SVH
`define OFP_REG_PULL_LO     3'h0
`define OFP_REG_PULL_HI     3'h1
`define OFP_REG_RANGE       3'h2
`define OFP_REG_RATIO_HI    3'h3
`define OFP_REG_RATIO_LO    3'h4
`define OFP_REG_DIVIDER     3'h5
`define OFP_REG_DRVSEL      3'h6
`define OFP_INT_MASK        5'h0E
`define OFP_DIV_MASK        13'h001B
`define OFP_OE_BIT          10
`define OFP_PULL_MAX        26'h1FFFFFF
`define OFP_PULL_MIN        26'h2000001
`define OFP_PULL_NEG_END    26'h2000000
`define OFP_RANGE_RST       4'h0
`define OFP_OE_RST          1'b0
`define OFP_CLK_MHZ         200
`define OFP_RELOCK_US       421
`define OFP_RELOCK_CYC      (`OFP_RELOCK_US * `OFP_CLK_MHZ)
`define OFP_PULL_KHZ        38
`define OFP_PULL_GAP_CYC    \
  ((`OFP_CLK_MHZ * 1000 + `OFP_PULL_KHZ - 1) / `OFP_PULL_KHZ)
`define OFP_AV_CTRL         5'h00
`define OFP_AV_STATUS       5'h04
`define OFP_AV_RATIO        5'h08
`define OFP_AV_DIV          5'h0C
`define OFP_AV_PULL         5'h10
`define OFP_AV_RANGE        5'h14
`define OFP_CTRL_PROG       0
`define OFP_CTRL_PULL       1
`define OFP_CTRL_RANGE      2
`endif

// *** common/ofp_pkg.sv ***
package ofp_pkg;
  typedef enum logic [8:0] {
    OFP_IDLE = 9'h001,
    OFP_RD6  = 9'h002,
    OFP_WR3  = 9'h004,
    OFP_WR4  = 9'h008,
    OFP_WR6  = 9'h010,
    OFP_WR5  = 9'h020,
    OFP_WRL  = 9'h040,
    OFP_WRH  = 9'h080,
    OFP_WRR  = 9'h100
  } ofp_state_t;
endpackage : ofp_pkg

// *** common/ofp_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface ofp_link_if;
  logic        req;
  logic        wr;
  logic [2:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        ack;
  modport dev  (input req, wr, addr, wdata, output rdata, ack);
  modport host (output req, wr, addr, wdata, input rdata, ack);
endinterface : ofp_link_if
`default_nettype wire

// *** verilog/ofp_device.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ofp_defines.svh"
module ofp_device
  import ofp_pkg::*;
#(
  parameter int RELOCK_CYC = `OFP_RELOCK_CYC
) (
  // Clock and reset
  input  wire logic  MCLK,
  input  wire logic  RST_B,
  // Register link
  ofp_link_if.dev    LINK,
  // Synthesis setting in force
  output logic [4:0]  RATIO_INT,
  output logic [26:0] RATIO_FRAC,
  output logic [12:0] OUTPUT_DIVIDER,
  output logic [5:0]  DRIVE,
  output logic        DRIVER_DIVIDE_BY_ONE,
  output logic        CLK_OUT_EN,
  output logic        RELOCKING,
  // Digital pull
  output logic [25:0] PULL_WORD,
  output logic [3:0]  PULL_RANGE,
  output logic        PULL_UPDATE
);
  logic [15:0] pull_lo;
  logic [9:0]  pull_hi;
  logic        oe_soft;
  logic [3:0]  range_sel;
  logic [15:0] ratio_hi;
  logic [15:0] ratio_lo;
  logic [15:0] divider;
  logic [15:0] drvsel;
  logic [16:0] relock_cnt;
  logic        wr_stb;
  logic [25:0] next_pull;

  assign wr_stb = LINK.req & LINK.wr & ~LINK.ack;
  assign next_pull = {LINK.wdata[9:0], pull_lo};

  // Link answers one cycle after a request, once
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      LINK.ack <= 1'b0;
    end else begin
      LINK.ack <= LINK.req & ~LINK.ack;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      LINK.rdata <= 16'h0000;
    end else if (LINK.req & ~LINK.ack) begin
      unique case (LINK.addr)
        `OFP_REG_PULL_LO:  LINK.rdata <= pull_lo;
        `OFP_REG_PULL_HI:  LINK.rdata <= {5'h00, oe_soft, pull_hi};
        `OFP_REG_RANGE:    LINK.rdata <= {12'h000, range_sel};
        `OFP_REG_RATIO_HI: LINK.rdata <= ratio_hi;
        `OFP_REG_RATIO_LO: LINK.rdata <= ratio_lo;
        `OFP_REG_DIVIDER:  LINK.rdata <= divider;
        `OFP_REG_DRVSEL:   LINK.rdata <= drvsel;
        default:           LINK.rdata <= 16'h0000;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      pull_lo  <= 16'h0000;
      pull_hi  <= 10'h000;
      ratio_hi <= 16'h0000;
      ratio_lo <= 16'h0000;
      divider  <= 16'h0000;
      drvsel   <= 16'h0000;
    end else if (wr_stb) begin
      unique case (LINK.addr)
        `OFP_REG_PULL_LO:  pull_lo  <= LINK.wdata;
        `OFP_REG_PULL_HI:  pull_hi  <= LINK.wdata[9:0];
        `OFP_REG_RATIO_HI: ratio_hi <= LINK.wdata;
        `OFP_REG_RATIO_LO: ratio_lo <= LINK.wdata;
        `OFP_REG_DIVIDER:  divider  <= LINK.wdata;
        `OFP_REG_DRVSEL:   drvsel   <= LINK.wdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      range_sel <= `OFP_RANGE_RST;
    end else if (wr_stb && LINK.addr == `OFP_REG_RANGE) begin
      range_sel <= LINK.wdata[3:0];
    end
  end

  // enable bit rides in the high write
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      oe_soft <= `OFP_OE_RST;
    end else if (wr_stb && LINK.addr == `OFP_REG_PULL_HI) begin
      oe_soft <= LINK.wdata[`OFP_OE_BIT];
    end
  end

  // pull applies on high write, clamped
  // The most negative code would overshoot the range by one step
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      PULL_WORD   <= 26'h0000000;
      PULL_UPDATE <= 1'b0;
    end else begin
      PULL_UPDATE <= wr_stb && LINK.addr == `OFP_REG_PULL_HI;
      if (wr_stb && LINK.addr == `OFP_REG_PULL_HI) begin
        if (next_pull == `OFP_PULL_NEG_END) begin
          PULL_WORD <= `OFP_PULL_MIN;
        end else begin
          PULL_WORD <= next_pull;
        end
      end
    end
  end

  // Range is only handed on with its own write
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      PULL_RANGE <= `OFP_RANGE_RST;
    end else begin
      PULL_RANGE <= range_sel;
    end
  end

  // commit decoded setting on divider write
  // Earlier writes stay shadowed so a half-written set never reaches the loop
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      RATIO_INT            <= `OFP_INT_MASK;
      RATIO_FRAC           <= 27'h0000000;
      OUTPUT_DIVIDER       <= `OFP_DIV_MASK;
      DRIVE                <= 6'h00;
      DRIVER_DIVIDE_BY_ONE <= 1'b0;
    end else if (wr_stb && LINK.addr == `OFP_REG_DIVIDER) begin
      RATIO_INT            <= ratio_hi[15:11] ^ `OFP_INT_MASK;
      RATIO_FRAC           <= {ratio_hi[10:0], ratio_lo};
      OUTPUT_DIVIDER       <= LINK.wdata[15:3] ^ `OFP_DIV_MASK;
      DRIVE                <= {LINK.wdata[2:0], drvsel[2:0]};
      DRIVER_DIVIDE_BY_ONE <= drvsel[3];
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      relock_cnt <= 17'h00000;
      RELOCKING  <= 1'b0;
    end else if (wr_stb && LINK.addr == `OFP_REG_DIVIDER) begin
      relock_cnt <= 17'(RELOCK_CYC - 1);
      RELOCKING  <= 1'b1;
    end else if (relock_cnt != 17'h00000) begin
      relock_cnt <= relock_cnt - 17'h00001;
    end else begin
      RELOCKING <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      CLK_OUT_EN <= 1'b0;
    end else begin
      CLK_OUT_EN <= oe_soft & ~RELOCKING &
                    ~(wr_stb && LINK.addr == `OFP_REG_DIVIDER);
    end
  end
endmodule : ofp_device
`default_nettype wire

// *** dv/ofp_link_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module ofp_link_monitor #(
  parameter int RELOCK_CYC = 20
) (
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        RST_B,
  // Register link
  input wire logic        req,
  input wire logic        wr,
  input wire logic [2:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        ack,
  // Device outputs
  input wire logic        RELOCKING,
  input wire logic        CLK_OUT_EN,
  input wire logic [25:0] PULL_WORD,
  input wire logic        PULL_UPDATE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  logic [31:0] relock_cnt;
  wire         take = req && !ack;

  // Length of one blanking window, compared when it ends
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      relock_cnt <= 32'h0;
    end else if (RELOCKING) begin
      relock_cnt <= relock_cnt + 32'h1;
    end else begin
      relock_cnt <= 32'h0;
    end
  end

  a_ack_one_cycle: assert property (take |=> ack ##1 !ack)
    else $error("link ack not a single pulse one cycle after request");
  a_req_held: assert property (take |=> req && $stable({wr, addr, wdata}))
    else $error("link request changed before ack");
  a_rdata_holds: assert property (!req |=> $stable(rdata))
    else $error("link read data moved without a request");
  a_commit_blanks: assert property (
    take && wr && addr == 3'h5 |-> ##[1:2] (RELOCKING && !CLK_OUT_EN))
    else $error("divider write did not start blanking");
  a_blank_relock: assert property (RELOCKING |-> !CLK_OUT_EN)
    else $error("output enabled during relock");
  a_relock_time: assert property (
    $fell(RELOCKING) |-> relock_cnt == RELOCK_CYC)
    else $error("relock window has wrong length");
  a_pull_on_high: assert property (
    PULL_UPDATE |-> ack && wr && addr == 3'h1)
    else $error("pull applied without a high word write");
  a_pull_upper: assert property (
    PULL_UPDATE |-> PULL_WORD[25:16] == wdata[9:0])
    else $error("applied pull upper bits differ from high word");
  a_pull_only_update: assert property (
    !$stable(PULL_WORD) |-> PULL_UPDATE)
    else $error("pull word changed without update");
  a_pull_in_range: assert property (PULL_WORD != 26'h2000000)
    else $error("pull word beyond negative range limit");

  c_relock: cover property ($fell(RELOCKING));
  c_pull: cover property (PULL_UPDATE);
  c_range: cover property (take && wr && addr == 3'h2);
  c_reenable: cover property ($fell(RELOCKING) ##1 CLK_OUT_EN);
endmodule // ofp_link_monitor
`default_nettype wire

// *** dv/osc_frequency_program_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module osc_frequency_program_ctrl_tb;
  import ofp_pkg::*;
  localparam int RELOCK = 20;
  localparam int GAP    = 10;

  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [4:0]  av_addr = 5'h00;
  logic        av_read = 1'b0;
  logic        av_write = 1'b0;
  logic [31:0] av_wdata = 32'h0;
  logic [31:0] av_rdata;
  logic        av_wait;
  logic [4:0]  ratio_int;
  logic [26:0] ratio_frac;
  logic [12:0] out_div;
  logic [5:0]  drive;
  logic        div1, clk_en, relocking, pull_upd;
  logic [25:0] pull_word;
  logic [3:0]  pull_range;
  logic [11:0] wseq = 12'h0;
  int          bad_count = 0, compares = 0, rl_cnt = 0;
  int          cyc = 0, last_up = -1, min_gap = 1000000;
  int          rl0 = 0;
  logic [31:0] exp_sel;
  logic [31:0] q;
  logic [31:0] rt [2] = '{32'h19E2CE1B, 32'h00000001};
  logic [31:0] dv [2] = '{32'h0005C019, 32'h000FE018};
  logic [31:0] pw [5] = '{32'h04E66666, 32'h07800000, 32'h05FFFFFF,
                          32'h06000000, 32'h00000000};
  logic [25:0] pe [5] = '{26'h0E66666, 26'h3800000, 26'h1FFFFFF,
                          26'h2000001, 26'h0000000};

  ofp_link_if lk ();

  ofp_device #(.RELOCK_CYC(RELOCK)) u_ofp_device (
    .MCLK(mclk), .RST_B(rst_b), .LINK(lk), .RATIO_INT(ratio_int),
    .RATIO_FRAC(ratio_frac), .OUTPUT_DIVIDER(out_div), .DRIVE(drive),
    .DRIVER_DIVIDE_BY_ONE(div1), .CLK_OUT_EN(clk_en),
    .RELOCKING(relocking), .PULL_WORD(pull_word),
    .PULL_RANGE(pull_range), .PULL_UPDATE(pull_upd));
  ofp_host #(.PULL_GAP_CYC(GAP)) u_ofp_host (
    .MCLK(mclk), .RST_B(rst_b), .AVS_ADDRESS(av_addr),
    .AVS_READ(av_read), .AVS_WRITE(av_write), .AVS_WRITEDATA(av_wdata),
    .AVS_READDATA(av_rdata), .AVS_WAITREQUEST(av_wait), .LINK(lk));
  ofp_link_monitor #(.RELOCK_CYC(RELOCK)) u_ofp_link_monitor (
    .MCLK(mclk), .RST_B(rst_b), .req(lk.req), .wr(lk.wr),
    .addr(lk.addr), .wdata(lk.wdata), .rdata(lk.rdata), .ack(lk.ack),
    .RELOCKING(relocking), .CLK_OUT_EN(clk_en), .PULL_WORD(pull_word),
    .PULL_UPDATE(pull_upd));

  always #2.5 mclk = ~mclk;

  // Link write order, blanking length and pull update spacing
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (lk.req === 1'b1 && lk.ack === 1'b1 && lk.wr === 1'b1)
      wseq <= {wseq[8:0], lk.addr};
    if (relocking === 1'b1) rl_cnt <= rl_cnt + 1;
    if (pull_upd === 1'b1) begin
      if (last_up >= 0 && cyc - last_up < min_gap) min_gap <= cyc - last_up;
      last_up <= cyc;
    end
  end

  task automatic tally_and_finish;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic timeout(input string nm);
    bad_count++;
    $display("[FAIL] %s expected done seen timeout", nm);
    tally_and_finish();
  endtask

  // Hold the request until waitrequest is sampled low
  task automatic av(input logic w, input logic [4:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge mclk);
    av_read <= !w;
    av_write <= w;
    av_addr <= a;
    av_wdata <= d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (av_wait !== 1'b0 && n < 50);
    q = av_rdata;
    av_read <= 1'b0;
    av_write <= 1'b0;
    if (n >= 50) timeout("waitrequest");
  endtask

  task automatic run_cmd(input logic [31:0] cmd);
    int n;
    // Snapshot instead of clearing, the monitor block owns these counters
    rl0 = rl_cnt;
    av(1'b1, 5'h00, cmd);
    n = 0;
    do begin
      av(1'b0, 5'h04, 32'h0);
      n++;
    end while (q[2:0] !== 3'b000 && n < 100);
    while (relocking !== 1'b0 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    repeat (2) @(posedge mclk);
    if (n >= 200) timeout("command");
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    check("rst_int", 32'h0E, 32'(ratio_int));
    check("rst_div", 32'h1B, 32'(out_div));
    check("rst_pull", 32'h0, 32'(pull_word));
    check("rst_range", 32'h0, 32'(pull_range));
    check("rst_en", 32'h0, 32'(clk_en));
    for (int i = 0; i < 2; i++) begin
      av(1'b1, 5'h08, rt[i]);
      av(1'b1, 5'h0C, dv[i]);
      run_cmd(32'h1);
      check("prog_order", {3'h3, 3'h4, 3'h6, 3'h5}, 32'(wseq));
      check("relock_len", RELOCK, rl_cnt - rl0);
      check("ratio_int", 32'(rt[i][31:27] ^ 5'h0E), 32'(ratio_int));
      check("ratio_frac", 32'(rt[i][26:0]), 32'(ratio_frac));
      check("divider", 32'(dv[i][12:0] ^ 13'h001B), 32'(out_div));
      check("drive", 32'(dv[i][18:13]), 32'(drive));
      check("div_by_one", 32'(dv[i][19]), 32'(div1));
      av(1'b0, 5'h08, 32'h0);
      check("rd_ratio", rt[i], q);
      av(1'b0, 5'h0C, 32'h0);
      check("rd_div", dv[i], q);
      exp_sel = (i == 0) ? 32'h0 : 32'({dv[0][19], dv[0][15:13]});
      av(1'b0, 5'h04, 32'h0);
      check("rd_sel_kept", exp_sel, 32'(q[31:16]));
    end
    for (int i = 0; i < 5; i++) begin
      av(1'b1, 5'h10, pw[i]);
      exp_sel = (i == 0) ? 32'h0 : 32'(pe[i - 1]);
      check("pull_held", exp_sel, 32'(pull_word));
      run_cmd(32'h2);
      check("pull_order", {3'h0, 3'h1}, 32'(wseq[5:0]));
      check("pull_word", 32'(pe[i]), 32'(pull_word));
      check("out_en", 32'(pw[i][26]), 32'(clk_en));
    end
    check("pull_gap_ok", 32'h1, 32'(min_gap >= GAP));
    for (int i = 0; i < 16; i++) begin
      av(1'b1, 5'h14, 32'(i));
      run_cmd(32'h4);
      check("range", 32'(i), 32'(pull_range));
      av(1'b0, 5'h14, 32'h0);
      check("rd_range", 32'(i), q);
    end
    // Reprogram with the output enabled so blanking is really seen
    av(1'b1, 5'h10, pw[0]);
    run_cmd(32'h2);
    run_cmd(32'h1);
    check("relock_len_en", RELOCK, rl_cnt - rl0);
    check("out_en_relock", 32'h1, 32'(clk_en));
    av(1'b1, 5'h18, 32'hFFFFFFFF);
    av(1'b0, 5'h18, 32'h0);
    check("unmapped", 32'h0, q);
    av(1'b0, 5'h08, 32'h0);
    check("rd_ratio_kept", rt[1], q);
    tally_and_finish();
  end

  initial begin
    repeat (100000) @(posedge mclk);
    timeout("run");
  end
endmodule // osc_frequency_program_ctrl_tb
`default_nettype wire
